// [src/ocd_pkg.sv]
// Purpose: Shared constants and types for the output-channel divider block.
// Assumes: One divider input clock; registers written through the serial port back end.
// Notes: Offsets are the register addresses as seen on the serial control port.
package ocd_pkg;
	// Register addresses, per group: counts, control, power and correction.
	localparam logic [9:0] ADDR_G1_COUNTS = 10'h193;
	localparam logic [9:0] ADDR_G1_CTRL = 10'h194;
	localparam logic [9:0] ADDR_G1_PWR = 10'h195;
	localparam logic [9:0] ADDR_G2_COUNTS = 10'h196;
	localparam logic [9:0] ADDR_G2_CTRL = 10'h197;
	localparam logic [9:0] ADDR_G2_PWR = 10'h198;
	// Reset values.
	localparam logic [7:0] RST_G1_COUNTS = 8'h33;
	localparam logic [7:0] RST_G2_COUNTS = 8'h11;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_PWR = 8'h00;
	// Count register fields.
	localparam int LOW_MSB = 7;
	localparam int LOW_LSB = 4;
	localparam int HIGH_MSB = 3;
	localparam int HIGH_LSB = 0;
	// Control register fields.
	localparam int BIT_BYPASS = 7;
	localparam int BIT_IGNORE = 6;
	localparam int BIT_FORCE = 5;
	localparam int BIT_START = 4;
	localparam int PHASE_MSB = 3;
	localparam int PHASE_LSB = 0;
	// Power and correction register fields.
	localparam int BIT_PWRDN = 2;
	localparam int BIT_DCC_OFF = 0;
	// Divider sequencing states.
	typedef enum logic [1:0] {
		ST_HOLD,
		ST_DELAY,
		ST_RUN
	} ocd_state_type;
endpackage : ocd_pkg

// [src/ocd_divider.sv]
// Purpose: Two output-group channel dividers with their configuration registers.
// Assumes: ref_clk is the divider input clock; syncN is an asynchronous pin.
// Notes: Bypass output toggles every rising edge, the nearest a flip-flop gets to the raw clock.
`timescale 1ns/100ps

module ocd_chan_div (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [7:0] cntReg,
	input wire logic [7:0] ctlReg,
	input wire logic dccOff,
	input wire logic syncActive,
	output logic divOut
);
	ocd_pkg::ocd_state_type state;
	ocd_pkg::ocd_state_type next_state;
	logic [4:0] cnt;
	logic [4:0] next_cnt;
	logic next_divOut;
	logic [3:0] lowCnt;
	logic [3:0] highCnt;
	logic [3:0] phase;
	logic bypass;
	logic ignore;
	logic [5:0] period;
	logic [4:0] lowEff;
	logic [4:0] highEff;
	logic [4:0] phaseLen;

	assign lowCnt = cntReg[ocd_pkg::LOW_MSB:ocd_pkg::LOW_LSB];
	assign highCnt = cntReg[ocd_pkg::HIGH_MSB:ocd_pkg::HIGH_LSB];
	assign phase = ctlReg[ocd_pkg::PHASE_MSB:ocd_pkg::PHASE_LSB];
	assign bypass = ctlReg[ocd_pkg::BIT_BYPASS];
	assign ignore = ctlReg[ocd_pkg::BIT_IGNORE];

	// Correction splits the whole period evenly; an odd period leaves the extra cycle high.
	always_comb begin
		period = 6'({2'b00, lowCnt} + {2'b00, highCnt} + 6'h02);
		if (dccOff) begin
			lowEff = 5'({1'b0, lowCnt} + 5'h01);
			highEff = 5'({1'b0, highCnt} + 5'h01);
		end else begin
			lowEff = period[5:1];
			highEff = 5'(period - {1'b0, period[5:1]});
		end
		phaseLen = divOut ? highEff : lowEff;
	end

	// Next-state logic; bypass beats force, force beats sync, sync beats counting.
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_divOut = divOut;
		if (bypass) begin
			next_state = ocd_pkg::ST_HOLD;
			next_cnt = 5'h00;
			next_divOut = ~divOut;
		end else if (ignore) begin
			// The force level is meaningful only with the sync disregarded.
			next_state = ocd_pkg::ST_HOLD;
			next_cnt = 5'h00;
			next_divOut = ctlReg[ocd_pkg::BIT_FORCE];
		end else if (syncActive) begin
			next_state = ocd_pkg::ST_HOLD;
			next_cnt = 5'h00;
			next_divOut = ctlReg[ocd_pkg::BIT_START];
		end else begin
			unique case (state)
				ocd_pkg::ST_HOLD: begin
					next_cnt = 5'h00;
					next_divOut = ctlReg[ocd_pkg::BIT_START];
					if (phase == 4'h0) begin
						next_state = ocd_pkg::ST_RUN;
					end else begin
						next_state = ocd_pkg::ST_DELAY;
					end
				end
				ocd_pkg::ST_DELAY: begin
					if (cnt == 5'({1'b0, phase} - 5'h01)) begin
						next_state = ocd_pkg::ST_RUN;
						next_cnt = 5'h00;
					end else begin
						next_cnt = 5'(cnt + 5'h01);
					end
				end
				ocd_pkg::ST_RUN: begin
					// A count that shrinks mid-phase ends the phase at once instead of wrapping the counter.
					if (cnt >= 5'(phaseLen - 5'h01)) begin
						next_cnt = 5'h00;
						next_divOut = ~divOut;
					end else begin
						next_cnt = 5'(cnt + 5'h01);
					end
				end
				default: begin
					next_state = ocd_pkg::ST_HOLD;
				end
			endcase
		end
	end

	// State registers.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state <= ocd_pkg::ST_HOLD;
			cnt <= 5'h00;
			divOut <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			divOut <= next_divOut;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	logic running;
	assign running = (state == ocd_pkg::ST_RUN) && !bypass && !ignore && !syncActive;

	// Phase lengths with correction off are the plain fields plus one.
	a_low_length: assert property (running && dccOff && !divOut && cnt == {1'b0, lowCnt} |=> divOut)
		else $error("Low phase did not end after low count plus one.");
	a_high_length: assert property (running && dccOff && divOut && cnt == {1'b0, highCnt} |=> !divOut)
		else $error("High phase did not end after high count plus one.");
	a_phase_steady: assert property (running && cnt < 5'(phaseLen - 5'h01) |=> divOut == $past(divOut))
		else $error("Divider output changed inside a phase.");
	// Two bypass cycles in a row must give two toggles, so the output toggles on every rising input edge.
	a_bypass_toggle: assert property (bypass ##1 bypass
		|=> divOut != $past(divOut) && divOut == $past(divOut, 2))
		else $error("Bypass did not pass the input clock through.");
	// Control-bit checks: sync hold, forced level, start level and phase delay.
	a_sync_hold: assert property (!bypass && !ignore && syncActive |=> state == ocd_pkg::ST_HOLD && cnt == 5'h00)
		else $error("Divider not held by chip sync.");
	a_force_level: assert property (!bypass && ignore |=> divOut == $past(ctlReg[ocd_pkg::BIT_FORCE]))
		else $error("Forced output level wrong.");
	a_start_level: assert property (state == ocd_pkg::ST_HOLD && !bypass && !ignore && !syncActive
		|=> divOut == $past(ctlReg[ocd_pkg::BIT_START]))
		else $error("Divider did not begin at the start level.");
	a_phase_delay: assert property (state == ocd_pkg::ST_HOLD && !bypass && !ignore && !syncActive && phase == 4'h2
		##1 !bypass && !ignore && !syncActive && $stable(ctlReg) |=> state == ocd_pkg::ST_DELAY)
		else $error("Phase offset did not delay the start.");
	// With correction on, the low phase ends once twice its length reaches the period, rounding down.
	a_dcc_even: assert property (running && !dccOff && !divOut
		&& 6'({cnt, 1'b0}) + 6'h03 >= 6'({2'b00, lowCnt} + {2'b00, highCnt} + 6'h02) |=> divOut)
		else $error("Corrected low phase did not end at half the period.");

	// Main scenarios: plain division, bypass and a delayed start.
	c_run_low: cover property (running && !divOut ##1 running && divOut);
	c_bypass: cover property (bypass [*3]);
	c_delay_run: cover property (state == ocd_pkg::ST_DELAY ##1 state == ocd_pkg::ST_RUN);
endmodule : ocd_chan_div

module ocd_divider (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic syncN,
	input wire logic regWr,
	input wire logic [9:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	output logic group1OutputA,
	output logic group1OutputB,
	output logic group1OutputC,
	output logic group1OeN,
	output logic group2OutputA,
	output logic group2OutputB,
	output logic group2OutputC,
	output logic group2OeN
);
	logic [7:0] cntR [2];
	logic [7:0] ctlR [2];
	logic [7:0] pwrR [2];
	logic [7:0] next_cntR [2];
	logic [7:0] next_ctlR [2];
	logic [7:0] next_pwrR [2];
	logic [7:0] next_regRdata;
	logic [2:0] syncPipe;
	logic syncActive;
	logic next_syncActive;
	logic [1:0] divOut;
	logic [1:0] groupOut;
	logic [1:0] groupOeN;
	logic [1:0] next_groupOeN;

	// Register writes and the read mux; unmapped addresses read as zero.
	always_comb begin
		next_cntR = cntR;
		next_ctlR = ctlR;
		next_pwrR = pwrR;
		next_regRdata = 8'h00;
		unique case (regAddr)
			ocd_pkg::ADDR_G1_COUNTS: next_regRdata = cntR[0];
			ocd_pkg::ADDR_G1_CTRL: next_regRdata = ctlR[0];
			ocd_pkg::ADDR_G1_PWR: next_regRdata = pwrR[0];
			ocd_pkg::ADDR_G2_COUNTS: next_regRdata = cntR[1];
			ocd_pkg::ADDR_G2_CTRL: next_regRdata = ctlR[1];
			ocd_pkg::ADDR_G2_PWR: next_regRdata = pwrR[1];
			default: next_regRdata = 8'h00;
		endcase
		if (regWr) begin
			unique case (regAddr)
				ocd_pkg::ADDR_G1_COUNTS: next_cntR[0] = regWdata;
				ocd_pkg::ADDR_G1_CTRL: next_ctlR[0] = regWdata;
				ocd_pkg::ADDR_G1_PWR: next_pwrR[0] = regWdata;
				ocd_pkg::ADDR_G2_COUNTS: next_cntR[1] = regWdata;
				ocd_pkg::ADDR_G2_CTRL: next_ctlR[1] = regWdata;
				ocd_pkg::ADDR_G2_PWR: next_pwrR[1] = regWdata;
				default: next_regRdata = 8'h00;
			endcase
		end
	end

	// Sync level moves only once the second and third stages agree, filtering a glitch.
	always_comb begin
		next_syncActive = syncActive;
		if (syncPipe[1] == syncPipe[2]) begin
			next_syncActive = ~syncPipe[2];
		end
		// Power-down takes effect one edge after the power bit is written.
		for (int g = 0; g < 2; g++) begin
			next_groupOeN[g] = pwrR[g][ocd_pkg::BIT_PWRDN];
		end
	end

	// Register file, synchroniser and output stage.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			cntR[0] <= ocd_pkg::RST_G1_COUNTS;
			cntR[1] <= ocd_pkg::RST_G2_COUNTS;
			ctlR[0] <= ocd_pkg::RST_CTRL;
			ctlR[1] <= ocd_pkg::RST_CTRL;
			pwrR[0] <= ocd_pkg::RST_PWR;
			pwrR[1] <= ocd_pkg::RST_PWR;
			regRdata <= 8'h00;
			syncPipe <= 3'h7;
			syncActive <= 1'b0;
			groupOut <= 2'h0;
			groupOeN <= 2'h3;
		end else begin
			cntR <= next_cntR;
			ctlR <= next_ctlR;
			pwrR <= next_pwrR;
			regRdata <= next_regRdata;
			syncPipe <= {syncPipe[1:0], syncN};
			syncActive <= next_syncActive;
			groupOut <= divOut;
			groupOeN <= next_groupOeN;
		end
	end

	// One divider per group; each drives its three outputs together.
	for (genvar g = 0; g < 2; g++) begin : gen_chan
		ocd_chan_div u_chan (
			.ref_clk(ref_clk),
			.nrst(nrst),
			.cntReg(cntR[g]),
			.ctlReg(ctlR[g]),
			.dccOff(pwrR[g][ocd_pkg::BIT_DCC_OFF]),
			.syncActive(syncActive),
			.divOut(divOut[g])
		);
	end

	// The three pins of a group share one flop, so they never skew against each other.
	assign group1OutputA = groupOut[0];
	assign group1OutputB = groupOut[0];
	assign group1OutputC = groupOut[0];
	assign group1OeN = groupOeN[0];
	assign group2OutputA = groupOut[1];
	assign group2OutputB = groupOut[1];
	assign group2OutputC = groupOut[1];
	assign group2OeN = groupOeN[1];

	default clocking cbt @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	a_power_down: assert property (regWr && regAddr == ocd_pkg::ADDR_G2_PWR && regWdata[ocd_pkg::BIT_PWRDN]
		|=> ##1 group2OeN)
		else $error("Group two outputs not released on power-down.");
	// The enable of group one follows its power bit one edge later.
	a_group1_power: assert property (1'b1 |=> group1OeN == $past(pwrR[0][ocd_pkg::BIT_PWRDN]))
		else $error("Group one enable does not follow its power bit.");
	// A sync level counts only once the last two stages agree, so a single glitch never reaches the dividers.
	a_sync_filter: assert property (syncPipe[1] != syncPipe[2] |=> $stable(syncActive))
		else $error("Sync level moved on a disagreeing sample.");
	// Read data shows the addressed register one edge after the address is presented.
	a_read_ctrl: assert property (regAddr == ocd_pkg::ADDR_G2_CTRL |=> regRdata == $past(ctlR[1]))
		else $error("Group two control register read back wrong.");

	c_power_down: cover property (!group2OeN ##1 group2OeN);
	c_sync_release: cover property (syncActive ##1 !syncActive);
endmodule : ocd_divider

// [dv/ocd_clk_sink.sv]
// Purpose: Receiver model that times the high and low runs of one divided clock.
// Assumes: Runs are counted in divider input cycles.
// Notes: While the driver is in high impedance the counts freeze.
`timescale 1ns/100ps

module ocd_clk_sink (
	input wire logic ref_clk,
	input wire logic clkIn,
	input wire logic oeN,
	output int lowLen,
	output int highLen,
	output int curLen
);
	logic prevLvl = 1'b0;

	// A finished run is logged on the edge that first sees the new level.
	always @(posedge ref_clk) begin
		if (oeN === 1'b0) begin
			if (clkIn !== prevLvl) begin
				if (prevLvl) highLen <= curLen;
				else lowLen <= curLen;
				curLen <= 1;
			end else curLen <= curLen + 1;
			prevLvl <= clkIn;
		end
	end
endmodule : ocd_clk_sink

// [dv/testbench.sv]
// Purpose: Self-checking bench for the two output-group dividers.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Run lengths are read from the receiver models.
`timescale 1ns/100ps

module testbench;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic syncN = 1'b1;
	logic regWr = 1'b0;
	logic [9:0] regAddr = 10'h000;
	logic [7:0] regWdata = 8'h00;
	logic [7:0] regRdata;
	logic g1A, g1B, g1C, g1OeN, g2A, g2B, g2C, g2OeN;
	int lo1, hi1, lo2, hi2, cur2;
	int nFail = 0;
	int testsRun = 0;
	logic [9:0] ra [6] = '{10'h193, 10'h194, 10'h195, 10'h196, 10'h197, 10'h198};
	logic [7:0] rv [6] = '{8'h33, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00};

	ocd_divider uut (.ref_clk(ref_clk), .nrst(nrst), .syncN(syncN), .regWr(regWr),
		.regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
		.group1OutputA(g1A), .group1OutputB(g1B), .group1OutputC(g1C), .group1OeN(g1OeN),
		.group2OutputA(g2A), .group2OutputB(g2B), .group2OutputC(g2C), .group2OeN(g2OeN));
	ocd_clk_sink sink1 (.ref_clk(ref_clk), .clkIn(g1A), .oeN(g1OeN), .lowLen(lo1), .highLen(hi1), .curLen());
	ocd_clk_sink sink2 (.ref_clk(ref_clk), .clkIn(g2A), .oeN(g2OeN), .lowLen(lo2), .highLen(hi2), .curLen(cur2));

	// Clock at 250 MHz.
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic ck(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			nFail++;
			$display("mismatch %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : ck

	// The strobe waits an edge first so that back-to-back writes never reassign it in one step.
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1 regWr = 1'b1;
		regAddr = a;
		regWdata = d;
		@(posedge ref_clk);
		#1 regWr = 1'b0;
	endtask : wr

	task automatic rd(input logic [9:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		#1 regAddr = a;
		@(posedge ref_clk);
		#1 ck(regRdata, exp);
	endtask : rd

	// Sixty cycles cover two full periods of the longest ratio here plus a run cut short by new counts.
	task automatic meas(input int lo, input int hi);
		repeat (60) @(posedge ref_clk);
		#1 ck(lo2, lo);
		ck(hi2, hi);
	endtask : meas

	task automatic stat(input logic v);
		repeat (12) @(posedge ref_clk);
		#1 ck(cur2 >= 8, 1);
		ck({g2A, g2B, g2C}, {3{v}});
	endtask : stat

	// Group two, offset by two cycles, must repeat group one's level from two edges earlier.
	task automatic lag;
		logic d1;
		logic d2;
		repeat (20) @(posedge ref_clk);
		#1 d2 = g1A;
		@(posedge ref_clk);
		#1 d1 = g1A;
		repeat (8) begin
			@(posedge ref_clk);
			#1 ck(g2A, d2);
			d2 = d1;
			d1 = g1A;
		end
	endtask : lag

	task automatic test_done;
		if (nFail == 0 && testsRun > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	// Watchdog sized well beyond the few hundred cycles the sequence needs.
	initial begin
		#20000;
		nFail++;
		test_done();
	end

	initial begin
		repeat (5) @(posedge ref_clk);
		#1 nrst = 1'b1;
		for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
		meas(2, 2);
		ck(lo1, 4);
		ck(hi1, 4);
		wr(10'h196, 8'h31);
		meas(3, 3);
		wr(10'h198, 8'h01);
		meas(4, 2);
		wr(10'h196, 8'h0F);
		meas(1, 16);
		wr(10'h196, 8'h11);
		wr(10'h198, 8'h00);
		wr(10'h197, 8'h80);
		meas(1, 1);
		// Sync held with the start level high, then low, then ignored with the force level high, then low.
		syncN = 1'b0;
		wr(10'h197, 8'h10);
		stat(1'b1);
		wr(10'h197, 8'h00);
		stat(1'b0);
		wr(10'h197, 8'h70);
		stat(1'b1);
		wr(10'h197, 8'h40);
		stat(1'b0);
		syncN = 1'b1;
		wr(10'h197, 8'h00);
		meas(2, 2);
		// Equal counts in both groups, group two offset by two, both restarted by one sync pulse.
		syncN = 1'b0;
		wr(10'h196, 8'h33);
		wr(10'h197, 8'h02);
		syncN = 1'b1;
		lag();
		wr(10'h198, 8'h04);
		repeat (3) @(posedge ref_clk);
		#1 ck(g2OeN, 1);
		ck(g1OeN, 0);
		wr(10'h198, 8'h00);
		repeat (3) @(posedge ref_clk);
		#1 ck(g2OeN, 0);
		// A reset in mid-run brings written registers back to their defaults.
		rd(10'h197, 8'h02);
		nrst = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1 nrst = 1'b1;
		rd(10'h196, 8'h11);
		rd(10'h197, 8'h00);
		test_done();
	end
endmodule : testbench
